/* hw/isa_pkg.sv */
// Shared constants for the serial slave front end and its bus master.
// Assumes a 125 MHz system clock on both ends.
package isa_pkg;
    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int CLK_KHZ     = 125000;
    localparam int SCL_MIN_KHZ = 100;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_KHZ     = 100;
    localparam int TMR_W       = 16;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam int         ADDR_W     = 7;
    localparam int         LOW_W      = 3;
    localparam int         UP_W       = 4;
    localparam int         BYTE_W     = 8;
    localparam int         LVL_W      = 8;
    localparam logic [3:0] UPPER_RST  = 4'hc;
    localparam logic [2:0] RES_SETTLE = 3'h4;
    // Level thresholds for codes 1..7, ascending
    localparam logic [7:0] SEL_TH [0:6] = '{8'h10, 8'h30, 8'h50, 8'h70,
                                            8'h90, 8'hb0, 8'hf0};

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam logic       RW_READ  = 1'b1;
    localparam logic       RW_WRITE = 1'b0;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT  = 4'h8;

    // Master command codes
    localparam logic [1:0] OP_START = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_STOP  = 2'h3;
endpackage

/* hw/isa_link_if.sv */
// Two-wire open-drain link between master and slave.
// Pull-ups are modelled: a wire is low while any end enables its driver.
`timescale 1ns/1ps
interface isa_link_if;
    logic host_scl_oe;
    logic host_sda_oe;
    logic dev_scl_oe;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    assign scl = ~(host_scl_oe | dev_scl_oe);
    assign sda = ~(host_sda_oe | dev_sda_oe);

    modport host (
        output host_scl_oe,
        output host_sda_oe,
        input  scl,
        input  sda
    );
    modport dev (
        output dev_scl_oe,
        output dev_sda_oe,
        input  scl,
        input  sda
    );
endinterface

/* hw/isa_dev.sv */
// Slave end: address construction, write and read framing, rx buffer.
// Assumes the link wires are asynchronous to clk_sys_in.
//
// Contract
// - Low three address bits from select level
// - Ground gives 000, supply gives 111
// - Resistor steps give codes 001 to 110
// - Address is stored upper four over decoded
// - Instruction byte follows the address frame
// - Write: start, address+0, code, data, stop
// - Start is SDA falling while SCL high
// - Nine clocks per byte, receiver acknowledges
// - First write frame is address, bit low
// - Second frame instruction, later frames data
// - Read setup write phase ends without stop
// - Read phase: repeated start, address+1
// - Device sends data, master acknowledges it
// - Further bytes while master keeps acknowledging
// - Master ends read with nack, stop
// - Slave only, seven bit addressing
// - Blank device holds upper bits 1100
// - SCL runs between 100 and 400 kHz
`timescale 1ns/1ps
module isa_dev (
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    isa_link_if.dev         link,
    input  wire logic [7:0] addr_sel_level_in,
    input  wire logic       cfg_upper_we_in,
    input  wire logic [3:0] cfg_upper_in,
    output logic            addr_resolved_out,
    output logic [6:0]      dev_addr_out,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_instr_out,
    input  wire logic       rx_ready_in,
    input  wire logic       rd_valid_in,
    input  wire logic [7:0] rd_data_in,
    output logic            rd_ready_out
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        S_IDLE  = 10'h001,
        S_ADDR  = 10'h002,
        S_AACK  = 10'h004,
        S_WR    = 10'h008,
        S_PUSH  = 10'h010,
        S_WACK  = 10'h020,
        S_RLOAD = 10'h040,
        S_RD    = 10'h080,
        S_RACK  = 10'h100,
        S_IGN   = 10'h200
    } isa_dev_state_e;

    isa_dev_state_e st_q;
    logic           scl_s1;
    logic           scl_s2;
    logic           scl_s3;
    logic           sda_s1;
    logic           sda_s2;
    logic           sda_s3;
    logic [7:0]     lvl_s1;
    logic [7:0]     lvl_s2;
    logic [2:0]     settle_q;
    logic           resolved_q;
    logic [2:0]     low_q;
    logic [3:0]     upper_q;
    logic [6:0]     my_addr;
    logic [3:0]     bitc_q;
    logic [7:0]     sh_q;
    logic           rw_q;
    logic           first_q;
    logic           sda_oe_q;
    logic [8:0]     mem_q [0:1];
    logic           wp_q;
    logic           rp_q;
    logic [1:0]     cnt_q;
    logic           full;
    logic           push;
    logic           pop;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_det;
    logic           stop_det;
    logic           scl_hold_q;

    // ------------------------------------------------------------
    // Line synchronisers and condition detect
    // ------------------------------------------------------------
    // Sampling at 125 MHz leaves wide margin at 400 kHz
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {link.scl, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {link.sda, sda_s1, sda_s2};
        end
    end

    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign start_det = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    assign stop_det  = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

    // ------------------------------------------------------------
    // Address construction
    // ------------------------------------------------------------
    function automatic logic [2:0] sel_decode(input logic [7:0] lv);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (lv >= isa_pkg::SEL_TH[i]) begin
                c = 3'(i + 1);
            end
        end
        return c;
    endfunction

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lvl_s1 <= 8'h00;
            lvl_s2 <= 8'h00;
        end else begin
            lvl_s1 <= addr_sel_level_in;
            lvl_s2 <= lvl_s1;
        end
    end

    // Level is taken once; later pin changes are not followed
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            settle_q   <= 3'h0;
            resolved_q <= 1'b0;
            low_q      <= 3'h0;
        end else if (!resolved_q) begin
            if (settle_q == isa_pkg::RES_SETTLE - 3'h1) begin
                low_q      <= sel_decode(lvl_s2);
                resolved_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            upper_q <= isa_pkg::UPPER_RST;
        end else if (cfg_upper_we_in) begin
            upper_q <= cfg_upper_in;
        end
    end

    assign my_addr           = {upper_q, low_q};
    assign dev_addr_out      = my_addr;
    assign addr_resolved_out = resolved_q;

    // ------------------------------------------------------------
    // Receive buffer, two entries
    // ------------------------------------------------------------
    assign full         = (cnt_q == 2'h2);
    assign push         = (st_q == S_PUSH) && !full;
    assign rx_valid_out = (cnt_q != 2'h0);
    assign pop          = rx_valid_out && rx_ready_in;
    assign rx_data_out  = mem_q[rp_q][7:0];
    assign rx_instr_out = mem_q[rp_q][8];

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_q[0] <= 9'h000;
            mem_q[1] <= 9'h000;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= {first_q, sh_q};
                wp_q        <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    // Clock held low while waiting on the buffer or read data, and for one cycle after
    assign link.dev_scl_oe  = (st_q == S_PUSH) || (st_q == S_RLOAD) || scl_hold_q;

    // One extra low cycle so SDA settles before the master sees SCL rise
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scl_hold_q <= 1'b0;
        end else begin
            scl_hold_q <= (st_q == S_PUSH) || (st_q == S_RLOAD);
        end
    end
    assign link.dev_sda_oe  = sda_oe_q;
    assign rd_ready_out     = (st_q == S_RLOAD);

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q     <= S_IDLE;
            bitc_q   <= 4'h0;
            sh_q     <= 8'h00;
            rw_q     <= 1'b0;
            first_q  <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            st_q     <= S_ADDR;
            bitc_q   <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            st_q     <= S_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                S_ADDR, S_WR: begin
                    // Rises are counted, so the fall that ends a start is no bit
                    if (scl_rise) begin
                        sh_q   <= {sh_q[6:0], sda_s2};
                        bitc_q <= bitc_q + 4'h1;
                    end
                    if (scl_fall && bitc_q == isa_pkg::ACK_BIT) begin
                        bitc_q <= 4'h0;
                        if (st_q == S_WR) begin
                            st_q <= S_PUSH;
                        end else if (resolved_q && sh_q[7:1] == my_addr) begin
                            rw_q     <= sh_q[0];
                            sda_oe_q <= 1'b1;
                            st_q     <= S_AACK;
                        end else begin
                            st_q <= S_IGN;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        bitc_q   <= 4'h0;
                        first_q  <= 1'b1;
                        if (rw_q == isa_pkg::RW_READ) begin
                            st_q <= S_RLOAD;
                        end else begin
                            st_q <= S_WR;
                        end
                    end
                end
                S_PUSH: begin
                    if (!full) begin
                        sda_oe_q <= 1'b1;
                        first_q  <= 1'b0;
                        st_q     <= S_WACK;
                    end
                end
                S_WACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        st_q     <= S_WR;
                    end
                end
                S_RLOAD: begin
                    if (rd_valid_in) begin
                        sh_q     <= rd_data_in;
                        sda_oe_q <= ~rd_data_in[7];
                        bitc_q   <= 4'h0;
                        st_q     <= S_RD;
                    end
                end
                S_RD: begin
                    if (scl_fall) begin
                        if (bitc_q == isa_pkg::LAST_BIT) begin
                            sda_oe_q <= 1'b0;
                            bitc_q   <= 4'h0;
                            st_q     <= S_RACK;
                        end else begin
                            sda_oe_q <= ~sh_q[6];
                            sh_q     <= {sh_q[6:0], 1'b0};
                            bitc_q   <= bitc_q + 4'h1;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise && sda_s2) begin
                        st_q <= S_IGN;
                    end else if (scl_fall) begin
                        st_q <= S_RLOAD;
                    end
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* hw/isa_host.sv */
// Master end: generates SCL by division and runs byte-level commands.
// Assumes one command at a time from logic on clk_sys_in.
`timescale 1ns/1ps
module isa_host #(
    parameter int SCL_KHZ = isa_pkg::SCL_KHZ
) (
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    isa_link_if.host        link,
    input  wire logic       cmd_valid_in,
    input  wire logic [1:0] cmd_op_in,
    input  wire logic [7:0] cmd_data_in,
    input  wire logic       cmd_nack_in,
    output logic            cmd_ready_out,
    output logic            rsp_valid_out,
    output logic [7:0]      rsp_data_out,
    output logic            rsp_ack_out,
    input  wire logic       rsp_ready_in
);
    // ------------------------------------------------------------
    // Timing and states
    // ------------------------------------------------------------
    localparam int QTR_I = isa_pkg::CLK_KHZ / (4 * SCL_KHZ);
    localparam logic [15:0] QTR = 16'(QTR_I);

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_START = 5'h02,
        H_BIT   = 5'h04,
        H_STOP  = 5'h08,
        H_RSP   = 5'h10
    } isa_host_state_e;

    isa_host_state_e st_q;
    logic [15:0]     tmr_q;
    logic [1:0]      ph_q;
    logic [3:0]      bitc_q;
    logic [8:0]      sh_q;
    logic [8:0]      rx_q;
    logic            scl_oe_q;
    logic            sda_oe_q;
    logic            scl_s1;
    logic            scl_s2;
    logic            sda_s1;
    logic            sda_s2;
    logic            hold;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {scl_s1, scl_s2} <= 2'h3;
            {sda_s1, sda_s2} <= 2'h3;
        end else begin
            {scl_s1, scl_s2} <= {link.scl, scl_s1};
            {sda_s1, sda_s2} <= {link.sda, sda_s1};
        end
    end

    assign link.host_scl_oe = scl_oe_q;
    assign link.host_sda_oe = sda_oe_q;
    assign cmd_ready_out    = (st_q == H_IDLE);
    assign rsp_valid_out    = (st_q == H_RSP);
    assign rsp_data_out     = rx_q[8:1];
    assign rsp_ack_out      = ~rx_q[0];
    // Waits while the slave stretches the clock
    assign hold             = (ph_q == 2'h2) && !scl_s2;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q     <= H_IDLE;
            tmr_q    <= 16'h0000;
            ph_q     <= 2'h0;
            bitc_q   <= 4'h0;
            sh_q     <= 9'h1ff;
            rx_q     <= 9'h000;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (st_q == H_IDLE) begin
            ph_q   <= 2'h0;
            bitc_q <= 4'h0;
            tmr_q  <= QTR;
            if (cmd_valid_in) begin
                case (cmd_op_in)
                    isa_pkg::OP_START: st_q <= H_START;
                    isa_pkg::OP_WRITE: begin
                        sh_q <= {cmd_data_in, 1'b1};
                        st_q <= H_BIT;
                    end
                    isa_pkg::OP_READ: begin
                        sh_q <= {8'hff, cmd_nack_in};
                        st_q <= H_BIT;
                    end
                    default: st_q <= H_STOP;
                endcase
            end
        end else if (st_q == H_RSP) begin
            if (rsp_ready_in) begin
                st_q <= H_IDLE;
            end
        end else if (hold) begin
            // High phase counted from SCL seen high, so a stretch never shortens it
            tmr_q <= QTR;
        end else if (tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
        end else begin
            tmr_q <= QTR;
            ph_q  <= ph_q + 2'h1;
            case (st_q)
                H_START: begin
                    case (ph_q)
                        2'h0: sda_oe_q <= 1'b0;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b1;
                        default: begin
                            scl_oe_q <= 1'b1;
                            st_q     <= H_IDLE;
                        end
                    endcase
                end
                H_BIT: begin
                    case (ph_q)
                        2'h0: sda_oe_q <= ~sh_q[8];
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: rx_q <= {rx_q[7:0], sda_s2};
                        default: begin
                            scl_oe_q <= 1'b1;
                            sh_q     <= {sh_q[7:0], 1'b1};
                            if (bitc_q == isa_pkg::ACK_BIT) begin
                                st_q <= H_RSP;
                            end else begin
                                bitc_q <= bitc_q + 4'h1;
                            end
                        end
                    endcase
                end
                default: begin
                    case (ph_q)
                        2'h0: begin
                            scl_oe_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                        end
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b0;
                        default: st_q <= H_IDLE;
                    endcase
                end
            endcase
        end
    end
endmodule

/* verification/isa_chk.sv */
// Checker on the two wires joining the master and slave ends.
// Assumes it sees the interface signals, clock and reset directly.
`timescale 1ns/1ps
module isa_chk (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic host_scl_oe,
    input  wire logic host_sda_oe,
    input  wire logic dev_scl_oe,
    input  wire logic dev_sda_oe,
    input  wire logic scl,
    input  wire logic sda
);
    localparam int PER_MIN = isa_pkg::CLK_KHZ / isa_pkg::SCL_MAX_KHZ;
    // ------------------------------------
    // Frame tracking
    // ------------------------------------
    logic        scl_q, sda_q, rw_q, frm_q, ign_q, rise, cnd;
    logic [3:0]  bit_q;
    logic [15:0] per_q;
    assign rise = scl & ~scl_q;
    assign cnd  = scl & scl_q & (sda ^ sda_q);
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {scl_q, sda_q, per_q} <= {2'b11, 16'h0000};
        end else begin
            {scl_q, sda_q} <= {scl, sda};
            per_q <= rise ? 16'h0000 : per_q + {15'h0000, per_q != 16'hffff};
        end
    end
    // Nack on address or read data means the slave must stay off the bus
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {bit_q, frm_q, rw_q, ign_q} <= {4'h0, 3'b000};
        end else if (cnd) begin
            {bit_q, frm_q, ign_q} <= {4'h0, 2'b00};
        end else if (rise) begin
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            frm_q <= frm_q | (bit_q == 4'h8);
            rw_q  <= (!frm_q && bit_q == 4'h7) ? sda : rw_q;
            ign_q <= ign_q | (bit_q == 4'h8 && sda && (!frm_q || rw_q));
        end
    end
    // ------------------------------------
    // Properties
    // ------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    AST_DEV_SDA_LOW: assert property ($changed(dev_sda_oe) |-> !scl && !scl_q)
        else $error("slave moved data while clock high");
    AST_ACK_NINTH: assert property (rise && dev_sda_oe && (!frm_q || !rw_q) |-> bit_q == 4'h8)
        else $error("slave drove data outside the ack slot");
    AST_MASTER_ACK: assert property (rise && frm_q && rw_q && !ign_q && bit_q != 4'h8
        |-> !host_sda_oe)
        else $error("master drove a read data bit");
    AST_IGNORE: assert property (ign_q |-> !dev_sda_oe)
        else $error("slave drove data after a nack");
    AST_START_HOLD: assert property (cnd && !sda |-> scl [*8])
        else $error("clock dropped right after start");
    AST_STOP_IDLE: assert property (cnd && sda |-> (scl && sda) [*8])
        else $error("bus not idle after stop");
    AST_SCL_PERIOD: assert property (rise |-> per_q >= PER_MIN)
        else $error("clock faster than allowed");
    AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    AST_DEV_SCL: assert property ($rose(dev_scl_oe) |-> !scl_q)
        else $error("slave pulled a high clock");
    COV_START: cover property (cnd && !sda);
    COV_READ: cover property (rise && frm_q && rw_q);
    COV_NACK: cover property ($rose(ign_q));
    COV_STRETCH: cover property (!host_scl_oe && dev_scl_oe);
endmodule

/* verification/test_i2c_slave_addr_and_framing.sv */
// Bench joining the master end and the slave end through one interface.
// Assumes both ends run on one clock; the wires carry modelled pull-ups.
`timescale 1ns/1ps
module test_i2c_slave_addr_and_framing;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk = 1'b0, nrst = 1'b0, cwe = 1'b0, hold = 1'b0, take = 1'b0;
    logic        cv = 1'b0, cnk = 1'b0, rxr = 1'b0, rspr = 1'b0, rdv = 1'b0;
    logic [7:0]  lvl = 8'h00, rdd = 8'h00, cdat = 8'h00;
    logic [1:0]  cop = 2'h0;
    logic [3:0]  cup = 4'h0;
    logic        res, rxv, rxi, rdr, crdy, rspv, rspa;
    logic [7:0]  rxd, rspd, ic;
    logic [7:0]  rb [2];
    logic [6:0]  dadr, adr;
    logic [8:0]  e;
    logic [8:0]  q_rsp [$];
    logic [8:0]  q_rx [$];
    logic [7:0]  q_rd [$];
    int          error_cnt = 0;
    int          n_checks = 0;
    isa_link_if  link ();
    isa_dev i_isa_dev (.clk_sys_in(clk), .nrst_in(nrst), .link(link),
        .addr_sel_level_in(lvl), .cfg_upper_we_in(cwe), .cfg_upper_in(cup),
        .addr_resolved_out(res), .dev_addr_out(dadr), .rx_valid_out(rxv),
        .rx_data_out(rxd), .rx_instr_out(rxi), .rx_ready_in(rxr),
        .rd_valid_in(rdv), .rd_data_in(rdd), .rd_ready_out(rdr));
    // Fastest legal clock keeps the run short
    isa_host #(.SCL_KHZ(isa_pkg::SCL_MAX_KHZ)) i_isa_host (.clk_sys_in(clk),
        .nrst_in(nrst), .link(link), .cmd_valid_in(cv), .cmd_op_in(cop),
        .cmd_data_in(cdat), .cmd_nack_in(cnk), .cmd_ready_out(crdy),
        .rsp_valid_out(rspv), .rsp_data_out(rspd), .rsp_ack_out(rspa),
        .rsp_ready_in(rspr));
    isa_chk i_isa_chk (.clk_sys_in(clk), .nrst_in(nrst),
        .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
        .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe),
        .scl(link.scl), .sda(link.sda));
    // ----------------------------------------
    // Drivers and monitors
    // ----------------------------------------
    always #4 clk = ~clk;
    // Idle read data toggles so a stale byte never passes
    always @(negedge clk) begin
        rxr <= ~hold & 1'($urandom_range(0, 1));
        rspr <= 1'($urandom_range(0, 1));
        if (take) void'(q_rd.pop_front());
        rdv <= q_rd.size() != 0;
        rdd <= (q_rd.size() != 0) ? q_rd[0] : ~rdd;
    end
    always @(posedge clk) begin
        take <= rdv & (rdr === 1'b1);
        if (nrst && rspv === 1'b1 && rspr) begin
            e = (q_rsp.size() != 0) ? q_rsp.pop_front() : ~{rspa, rspd};
            check({rspa, rspd}, e);
        end
        if (nrst && rxv === 1'b1 && rxr) begin
            e = (q_rx.size() != 0) ? q_rx.pop_front() : ~{rxi, rxd};
            check({rxi, rxd}, e);
        end
    end
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tmo();
        error_cnt++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        end_sim();
    endtask
    task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic nk,
                       input logic ack);
        for (int n = 0; crdy !== 1'b1; n++) begin
            if (n > 20000) tmo();
            @(negedge clk);
        end
        if (op == isa_pkg::OP_WRITE || op == isa_pkg::OP_READ) q_rsp.push_back({ack, d});
        {cv, cop, cdat, cnk} = {1'b1, op, d, nk};
        @(posedge clk);
        @(negedge clk);
        cv = 1'b0;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h6926_f99e));
        for (int k = 0; k < 8; k++) begin
            lvl = (k == 0) ? 8'h00 : (k == 7) ? 8'hff :
                8'($urandom_range(isa_pkg::SEL_TH[k-1], isa_pkg::SEL_TH[k] - 8'h01));
            nrst = 1'b0;
            repeat (2) @(negedge clk);
            nrst = 1'b1;
            check({8'h00, res}, 9'h000);
            for (int n = 0; res !== 1'b1; n++) begin
                if (n > 50) tmo();
                @(negedge clk);
            end
            check({5'h00, dadr[6:3]}, {5'h00, isa_pkg::UPPER_RST});
            check({6'h00, dadr[2:0]}, 9'(k));
        end
        cup = 4'($urandom);
        cwe = 1'b1;
        @(negedge clk);
        cwe = 1'b0;
        adr = {cup, 3'h7};
        check({2'h0, dadr}, {2'h0, adr});
        $display("test address done");
        hold = 1'b1;
        cmd(isa_pkg::OP_START, 8'h00, 1'b0, 1'b0);
        cmd(isa_pkg::OP_WRITE, {adr, isa_pkg::RW_WRITE}, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            ic = 8'($urandom);
            q_rx.push_back({i == 0, ic});
            cmd(isa_pkg::OP_WRITE, ic, 1'b0, 1'b1);
            if (i == 2) begin
                repeat (4000) @(negedge clk);
                check({8'h00, link.dev_scl_oe}, 9'h001);
                hold = 1'b0;
            end
        end
        cmd(isa_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
        $display("test write done");
        cmd(isa_pkg::OP_START, 8'h00, 1'b0, 1'b0);
        cmd(isa_pkg::OP_WRITE, {adr ^ 7'h01, isa_pkg::RW_WRITE}, 1'b0, 1'b0);
        cmd(isa_pkg::OP_WRITE, 8'ha5, 1'b0, 1'b0);
        cmd(isa_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
        $display("test mismatch done");
        ic = 8'($urandom);
        q_rx.push_back({1'b1, ic});
        for (int i = 0; i < 2; i++) begin
            rb[i] = 8'($urandom);
            q_rd.push_back(rb[i]);
        end
        cmd(isa_pkg::OP_START, 8'h00, 1'b0, 1'b0);
        cmd(isa_pkg::OP_WRITE, {adr, isa_pkg::RW_WRITE}, 1'b0, 1'b1);
        cmd(isa_pkg::OP_WRITE, ic, 1'b0, 1'b1);
        cmd(isa_pkg::OP_START, 8'h00, 1'b0, 1'b0);
        cmd(isa_pkg::OP_WRITE, {adr, isa_pkg::RW_READ}, 1'b0, 1'b1);
        for (int i = 0; i < 2; i++) cmd(isa_pkg::OP_READ, rb[i], i == 1, i == 0);
        cmd(isa_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
        for (int n = 0; crdy !== 1'b1 || q_rsp.size() + q_rx.size() != 0; n++) begin
            if (n > 20000) tmo();
            @(negedge clk);
        end
        $display("test read done");
        end_sim();
    end
endmodule
